//--- common/cfg_load_pkg.sv
// Shared constants for the serial configuration loader, device and host ends
package cfg_load_pkg;
   // ************************************************************
   // Clock and link timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_LOW_NS = 200;
   localparam int RESET_LOW_CYCLES = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLEAR_WAIT_US = 300;
   localparam int CLEAR_WAIT_CYCLES = (CLEAR_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF_CYCLES = 4;
   // ************************************************************
   // Image framing
   // ************************************************************
   localparam logic [31:0] SYNC_WORD = 32'h7EAA997E;
   localparam int BYTE_BITS = 8;
   localparam int DUMMY_CLOCKS = 49;
   localparam int IMAGE_BYTES = 16;
   localparam int DONE_WAIT_CLOCKS = 64;
endpackage

//--- common/cfg_load_if.sv
// Pin-level link between the configuration host and the loaded device
`timescale 1ns/10ps
interface cfg_load_if;
   logic config_reset_n;
   logic ss_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe_n;
   logic done_out;
   logic done_oe_n;
   logic load_complete_flag;
   logic so_level;
   // Pull-ups on both open pins: an undriven pin reads high
   assign load_complete_flag = done_oe_n ? 1'b1 : done_out;
   assign so_level = so_oe_n ? 1'b1 : so;
   modport device (
      input config_reset_n, ss_n, sck, si,
      output so, so_oe_n, done_out, done_oe_n
   );
   modport host (
      output config_reset_n, ss_n, sck, si,
      input load_complete_flag, so_level
   );
endinterface

//--- logic/cfg_load_device.sv
// Device end: serial peripheral configuration loader with image store
`timescale 1ns/10ps
// Behaviour
// - Host holds reset low at least 200 ns
// - Reset rising with select low enters peripheral load
// - Reset rising with select high enters master mode
// - Host waits 300 us before image bits
// - Memory cleared before image data accepted
// - Image must not use multi-image selection
// - Image sent in one continuous transfer
// - Clock rate held in range after sync
// - Bytes sent most significant bit first
// - Host changes data on falling clock edge
// - Device samples data on rising clock edge
// - Serial data output unused during load
// - Done released high after complete image
// - Failed load keeps done low; host flags error
// - Host gives 49 dummy clocks after done
// - Pins handed to user after dummy clocks
// - Reset pulse restarts whole configuration sequence
// - Select held low through reset and transfer
module cfg_load_device #(
   parameter int IMAGE_BYTES = cfg_load_pkg::IMAGE_BYTES,
   parameter int ADDR_W = $clog2(IMAGE_BYTES),
   parameter int CLEAR_WAIT_CYCLES = cfg_load_pkg::CLEAR_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Configuration link
   cfg_load_if.device link,
   // User side: loaded image read port
   input wire logic [ADDR_W-1:0] cfg_addr_in,
   output logic [7:0] cfg_data_out,
   // User side: status and handed-over pins
   output logic configured_out,
   output logic master_mode_out,
   output logic load_error_out,
   output logic [2:0] user_pins_out,
   input wire logic user_so_in
);
   typedef enum logic [7:0] {
      ST_HOLD = 8'h01,
      ST_CLEAR = 8'h02,
      ST_HUNT = 8'h04,
      ST_LOAD = 8'h08,
      ST_TRAIL = 8'h10,
      ST_USER = 8'h20,
      ST_MASTER = 8'h40,
      ST_FAIL = 8'h80
   } state_type;

   localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(IMAGE_BYTES - 1);
   localparam logic [5:0] LAST_DUMMY = 6'(cfg_load_pkg::DUMMY_CLOCKS - 1);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [1:0] rst_sync;
   logic [1:0] ss_sync;
   logic [1:0] sck_sync;
   logic [1:0] si_sync;
   logic sck_prev;
   logic rst_prev;
   logic sck_rise;
   logic rst_rise;
   logic rst_level;
   logic ss_level;
   logic si_level;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync <= 2'h0;
         ss_sync <= 2'h3;
         sck_sync <= 2'h0;
         si_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], link.config_reset_n};
         ss_sync <= {ss_sync[0], link.ss_n};
         sck_sync <= {sck_sync[0], link.sck};
         si_sync <= {si_sync[0], link.si};
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sck_prev <= 1'b0;
         rst_prev <= 1'b0;
      end else begin
         sck_prev <= sck_sync[1];
         rst_prev <= rst_sync[1];
      end
   end

   assign rst_level = rst_sync[1];
   assign ss_level = ss_sync[1];
   assign si_level = si_sync[1];
   // Data is taken on the rising serial clock only while selected
   assign sck_rise = sck_sync[1] & ~sck_prev & ~ss_level;
   assign rst_rise = rst_level & ~rst_prev;

   // ************************************************************
   // Sequence control
   // ************************************************************
   state_type state;
   state_type next_state;
   logic [ADDR_W-1:0] clear_addr;
   logic [ADDR_W-1:0] load_addr;
   logic [31:0] hunt_shift;
   logic [7:0] byte_shift;
   logic [2:0] bit_count;
   logic [5:0] dummy_count;
   logic [$clog2(CLEAR_WAIT_CYCLES+1)-1:0] clear_timer;
   logic byte_done;

   assign byte_done = sck_rise && (bit_count == 3'h7);

   always_comb begin
      next_state = state;
      case (state)
         ST_HOLD: begin
            if (rst_rise) begin
               next_state = ss_level ? ST_MASTER : ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            // Data is ignored until every word is cleared
            if (clear_addr == LAST_ADDR) begin
               next_state = ST_HUNT;
            end
         end
         ST_HUNT: begin
            if ({hunt_shift[30:0], si_level} == cfg_load_pkg::SYNC_WORD && sck_rise) begin
               next_state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (ss_level) begin
               next_state = ST_FAIL;
            end else if (byte_done && load_addr == LAST_ADDR) begin
               next_state = ST_TRAIL;
            end
         end
         ST_TRAIL: begin
            if (sck_rise && dummy_count == LAST_DUMMY) begin
               next_state = ST_USER;
            end
         end
         ST_USER: next_state = ST_USER;
         ST_MASTER: next_state = ST_MASTER;
         ST_FAIL: next_state = ST_FAIL;
         default: next_state = ST_HOLD;
      endcase
      // A reset pulse overrides everything and starts again
      if (!rst_level) begin
         next_state = ST_HOLD;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // Clear walk; the wait timer only shows how long the clear window lasts
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         clear_addr <= '0;
         clear_timer <= '0;
      end else if (state != ST_CLEAR) begin
         clear_addr <= '0;
         clear_timer <= '0;
      end else begin
         clear_addr <= clear_addr + 1'b1;
         if (clear_timer != CLEAR_WAIT_CYCLES[$bits(clear_timer)-1:0]) begin
            clear_timer <= clear_timer + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hunt_shift <= 32'h0;
      end else if (state != ST_HUNT) begin
         hunt_shift <= 32'h0;
      end else if (sck_rise) begin
         hunt_shift <= {hunt_shift[30:0], si_level};
      end
   end

   // Bytes assemble msb first
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         byte_shift <= 8'h00;
         bit_count <= 3'h0;
         load_addr <= '0;
      end else if (state != ST_LOAD) begin
         bit_count <= 3'h0;
         load_addr <= '0;
      end else if (sck_rise) begin
         byte_shift <= {byte_shift[6:0], si_level};
         bit_count <= bit_count + 3'h1;
         if (bit_count == 3'h7) begin
            load_addr <= load_addr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dummy_count <= 6'h00;
      end else if (state != ST_TRAIL) begin
         dummy_count <= 6'h00;
      end else if (sck_rise) begin
         dummy_count <= dummy_count + 6'h01;
      end
   end

   // ************************************************************
   // Image store
   // ************************************************************
   logic [7:0] image_mem [IMAGE_BYTES];

   always_ff @(posedge clk_in) begin
      if (state == ST_CLEAR) begin
         image_mem[clear_addr] <= 8'h00;
      end else if (state == ST_LOAD && byte_done) begin
         image_mem[load_addr] <= {byte_shift[6:0], si_level};
      end
   end

   // Contents are meaningful to the user only once configured
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cfg_data_out <= 8'h00;
      end else begin
         cfg_data_out <= image_mem[cfg_addr_in];
      end
   end

   // ************************************************************
   // Pin outputs
   // ************************************************************
   logic done_release;
   logic pins_free;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         done_release <= 1'b0;
         pins_free <= 1'b0;
      end else begin
         done_release <= next_state == ST_TRAIL || next_state == ST_USER;
         pins_free <= next_state == ST_USER;
      end
   end

   assign link.done_out = 1'b0;
   assign link.done_oe_n = done_release;
   // Serial output stays undriven while loading; the user owns it afterwards
   assign link.so = pins_free ? user_so_in : 1'b1;
   assign link.so_oe_n = ~pins_free;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         user_pins_out <= 3'h0;
         configured_out <= 1'b0;
         master_mode_out <= 1'b0;
         load_error_out <= 1'b0;
      end else begin
         user_pins_out <= pins_free ? {ss_level, sck_sync[1], si_level} : 3'h0;
         configured_out <= pins_free;
         master_mode_out <= state == ST_MASTER;
         load_error_out <= state == ST_FAIL;
      end
   end
endmodule

//--- logic/cfg_load_host.sv
// Host end: drives reset, select and serial clock to load one image
`timescale 1ns/10ps
module cfg_load_host #(
   parameter int WAIT_CYCLES = cfg_load_pkg::CLEAR_WAIT_CYCLES,
   parameter int SCK_HALF = cfg_load_pkg::SCK_HALF_CYCLES,
   parameter int DONE_WAIT = cfg_load_pkg::DONE_WAIT_CLOCKS
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Configuration link
   cfg_load_if.host link,
   // Image byte stream
   input wire logic start_in,
   input wire logic [7:0] byte_in,
   input wire logic byte_valid_in,
   input wire logic byte_last_in,
   output logic byte_ready_out,
   // Status
   output logic busy_out,
   output logic ok_out,
   output logic error_out
);
   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_RST = 6'h02,
      H_WAIT = 6'h04,
      H_SHIFT = 6'h08,
      H_DUMMY = 6'h10,
      H_END = 6'h20
   } hstate_type;

   hstate_type state;
   logic [$clog2(WAIT_CYCLES+1)-1:0] timer;
   logic [$clog2(SCK_HALF+1)-1:0] div;
   logic tick;
   logic sck;
   logic [7:0] shift;
   logic last_flag;
   logic [2:0] bit_count;
   logic [5:0] dummy_count;
   logic [$clog2(DONE_WAIT+1)-1:0] done_timer;
   logic [1:0] done_sync;
   logic rise;
   logic take;
   logic wait_end;

   // ************************************************************
   // Serial clock divider and done synchroniser
   // ************************************************************
   assign tick = div == $bits(div)'(SCK_HALF - 1);
   assign rise = tick && !sck;
   assign wait_end = state == H_WAIT && timer == $bits(timer)'(WAIT_CYCLES - 1);
   // Every byte is asked for SCK_HALF cycles before its first bit goes out, on the falling clock; a gap aborts
   assign take = wait_end || (state == H_SHIFT && rise && bit_count == 3'h7 && !last_flag);
   assign byte_ready_out = take;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div <= '0;
         done_sync <= 2'h0;
      end else begin
         div <= (tick || (state != H_SHIFT && state != H_DUMMY)) ? '0 : div + 1'b1;
         done_sync <= {done_sync[0], link.load_complete_flag};
      end
   end

   // ************************************************************
   // Sequence
   // ************************************************************
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= H_IDLE;
         timer <= '0;
         sck <= 1'b1;
         shift <= 8'h00;
         last_flag <= 1'b0;
         bit_count <= 3'h0;
         dummy_count <= 6'h00;
         done_timer <= '0;
         ok_out <= 1'b0;
         error_out <= 1'b0;
      end else begin
         case (state)
            H_IDLE: begin
               if (start_in) begin
                  state <= H_RST;
                  timer <= '0;
                  ok_out <= 1'b0;
                  error_out <= 1'b0;
               end
            end
            H_RST: begin
               timer <= timer + 1'b1;
               if (timer == $bits(timer)'(cfg_load_pkg::RESET_LOW_CYCLES - 1)) begin
                  state <= H_WAIT;
                  timer <= '0;
               end
            end
            H_WAIT: begin
               timer <= timer + 1'b1;
               if (wait_end) begin
                  state <= byte_valid_in ? H_SHIFT : H_END;
                  error_out <= !byte_valid_in;
                  shift <= byte_in;
                  last_flag <= byte_last_in;
                  bit_count <= 3'h0;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  sck <= !sck;
               end
               if (tick && sck) begin
                  shift <= {shift[6:0], 1'b1};
               end
               if (rise) begin
                  bit_count <= bit_count + 3'h1;
                  if (bit_count == 3'h7) begin
                     shift <= byte_in;
                     last_flag <= byte_last_in;
                     if (last_flag) begin
                        state <= H_DUMMY;
                        dummy_count <= 6'h00;
                        done_timer <= '0;
                     end else if (!byte_valid_in) begin
                        state <= H_END;
                        error_out <= 1'b1;
                     end
                  end
               end
            end
            H_DUMMY: begin
               if (tick) begin
                  sck <= !sck;
               end
               // Stop on the fall after the last counted rise: select rising with that rise would hide it
               if (tick && sck && dummy_count == 6'(cfg_load_pkg::DUMMY_CLOCKS)) begin
                  state <= H_END;
                  ok_out <= 1'b1;
               end
               if (rise && done_sync[1]) begin
                  dummy_count <= dummy_count + 6'h01;
               end else if (rise) begin
                  done_timer <= done_timer + 1'b1;
                  if (done_timer == $bits(done_timer)'(DONE_WAIT - 1)) begin
                     state <= H_END;
                     error_out <= 1'b1;
                  end
               end
            end
            H_END: begin
               sck <= 1'b1;
               state <= H_IDLE;
            end
            default: state <= H_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Pin drive
   // ************************************************************
   logic si_bit;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         si_bit <= 1'b1;
      end else if (state == H_SHIFT && tick && sck) begin
         si_bit <= shift[7];
      end else if (state == H_IDLE || (state != H_SHIFT && tick && sck)) begin
         // Back to idle as the clock falls, or at once in H_IDLE where the clock is held high
         si_bit <= 1'b1;
      end
   end

   assign link.config_reset_n = state != H_RST;
   // Select stays low from reset pulse through the dummy clocks
   assign link.ss_n = !(state == H_RST || state == H_WAIT || state == H_SHIFT || state == H_DUMMY);
   assign link.sck = sck;
   assign link.si = si_bit;
   assign busy_out = state != H_IDLE;
endmodule

//--- verification/cfg_load_properties.sv
// Concurrent checks on the configuration link between host and device ends
`timescale 1ns/10ps
module cfg_load_properties #(
   parameter int IMAGE_BYTES = cfg_load_pkg::IMAGE_BYTES
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Link signals
   input wire logic config_reset_n,
   input wire logic ss_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_oe_n,
   input wire logic done_oe_n,
   input wire logic load_complete_flag
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ************************************************************
   // Helper counters
   // ************************************************************
   logic sck_q;
   logic [15:0] bits;
   logic [15:0] dummies;
   wire sck_rise = sck && !sck_q;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) sck_q <= 1'b1;
      else sck_q <= sck;
   end
   // A reset pulse starts a new image, so both counts restart there
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) bits <= 16'h0000;
      else if (!config_reset_n) bits <= 16'h0000;
      else if (sck_rise && !ss_n) bits <= bits + 16'h0001;
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) dummies <= 16'h0000;
      else if (!config_reset_n) dummies <= 16'h0000;
      else if (sck_rise && load_complete_flag) dummies <= dummies + 16'h0001;
   end
   // ************************************************************
   // Properties
   // ************************************************************
   sequence reset_pulse_s;
      !config_reset_n [*4];
   endsequence
   sequence done_held_s;
      ##4 !done_oe_n;
   endsequence
   reset_low_a: assert property ($fell(config_reset_n) |-> reset_pulse_s)
      else $error("reset pulse too short");
   select_held_a: assert property (!config_reset_n |-> !ss_n)
      else $error("select high during reset pulse");
   entry_select_a: assert property ($rose(config_reset_n) |-> !ss_n [*8])
      else $error("select not low at reset release");
   data_edge_a: assert property ($changed(si) |-> !sck)
      else $error("data changed outside falling clock");
   done_low_a: assert property ($fell(config_reset_n) |-> done_held_s)
      else $error("done not driven low after reset");
   so_unused_a: assert property (!done_oe_n |-> so_oe_n)
      else $error("serial output driven during load");
   done_count_a: assert property ($rose(load_complete_flag) |->
      bits >= (IMAGE_BYTES + 4) * 8 && bits <= (IMAGE_BYTES + 4) * 8 + 1)
      else $error("done released at wrong bit count");
   done_stands_a: assert property (load_complete_flag && config_reset_n |=> load_complete_flag)
      else $error("done dropped without reset");
   failed_low_a: assert property (!load_complete_flag && ss_n |=> !load_complete_flag)
      else $error("done released while not selected");
   dummy_clocks_a: assert property ($rose(ss_n) && load_complete_flag |-> dummies >= 49)
      else $error("too few dummy clocks");
   handover_a: assert property ($fell(so_oe_n) |-> dummies >= 49 && load_complete_flag)
      else $error("pins handed over too early");
endmodule

//--- verification/spi_slave_config_loader_test.sv
// Self-checking bench: host end loads images into the device, plus a fault driver
`timescale 1ns/10ps
module spi_slave_config_loader_test;
   localparam int WAIT = 50;
   localparam int NB = cfg_load_pkg::IMAGE_BYTES;
   localparam int LEN = NB + 4;
   localparam int HALF = cfg_load_pkg::SCK_HALF_CYCLES;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic start_in = 1'b0;
   logic [7:0] byte_in = 8'h00;
   logic byte_valid_in = 1'b1;
   logic byte_last_in = 1'b0;
   logic byte_ready_out, busy_out, ok_out, error_out;
   logic [$clog2(NB)-1:0] cfg_addr_in = '0;
   logic [7:0] cfg_data_out;
   logic configured_out, master_mode_out, load_error_out;
   logic configured_b, master_b, error_b;
   logic [2:0] user_pins_out;
   logic user_so_in = 1'b1;
   logic [7:0] stream [LEN];
   int feed = 0;
   int mismatches = 0;
   int comparisons = 0;
   logic [31:0] wire_shift = 32'h00000000;
   logic sync_seen = 1'b0;
   logic sck_q = 1'b1;
   cfg_load_if link();
   cfg_load_if link_f();
   cfg_load_device #(.CLEAR_WAIT_CYCLES(WAIT)) u_cfg_load_device (.clk_in(clk_in), .rstn_in(rstn_in),
      .link(link), .cfg_addr_in(cfg_addr_in), .cfg_data_out(cfg_data_out), .configured_out(configured_out),
      .master_mode_out(master_mode_out), .load_error_out(load_error_out), .user_pins_out(user_pins_out),
      .user_so_in(user_so_in));
   // Second device faces the bench's own driver, which can break the link rules
   cfg_load_device #(.CLEAR_WAIT_CYCLES(WAIT)) u_cfg_load_device_f (.clk_in(clk_in), .rstn_in(rstn_in),
      .link(link_f), .cfg_addr_in('0), .cfg_data_out(), .configured_out(configured_b),
      .master_mode_out(master_b), .load_error_out(error_b), .user_pins_out(), .user_so_in(1'b0));
   cfg_load_host #(.WAIT_CYCLES(WAIT)) u_cfg_load_host (.clk_in(clk_in), .rstn_in(rstn_in), .link(link),
      .start_in(start_in), .byte_in(byte_in), .byte_valid_in(byte_valid_in), .byte_last_in(byte_last_in),
      .byte_ready_out(byte_ready_out), .busy_out(busy_out), .ok_out(ok_out), .error_out(error_out));
   cfg_load_properties #(.IMAGE_BYTES(NB)) u_cfg_load_properties (.clk_in(clk_in), .rstn_in(rstn_in),
      .config_reset_n(link.config_reset_n), .ss_n(link.ss_n), .sck(link.sck), .si(link.si),
      .so_oe_n(link.so_oe_n), .done_oe_n(link.done_oe_n), .load_complete_flag(link.load_complete_flag));
   always #25 clk_in = ~clk_in;
   initial begin
      link_f.config_reset_n <= 1'b1;
      link_f.ss_n <= 1'b1;
      link_f.sck <= 1'b1;
      link_f.si <= 1'b1;
   end
   // ************************************************************
   // Wire monitor and byte feeder
   // ************************************************************
   always @(posedge clk_in) begin
      sck_q <= link.sck;
      if (link.sck === 1'b1 && sck_q === 1'b0 && link.ss_n === 1'b0) wire_shift <= {wire_shift[30:0], link.si};
      if (wire_shift === cfg_load_pkg::SYNC_WORD) sync_seen <= 1'b1;
   end
   // In a valid load the next byte is always ready, so the image goes out without a pause
   always @(posedge clk_in) begin
      if (byte_ready_out === 1'b1 && feed < LEN - 1) begin
         feed <= feed + 1;
         byte_in <= stream[feed + 1];
         byte_last_in <= (feed + 1 == LEN - 1);
      end
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [7:0] img(input logic [7:0] seed, input int k);
      return seed + 8'(k) * 8'h1D;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic check(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic load(input logic [7:0] seed, input logic valid);
      // Sync word, then plain data bytes with no boot-image selection in them
      for (int k = 0; k < LEN; k++) begin
         stream[k] = (k < 4) ? cfg_load_pkg::SYNC_WORD[31 - 8 * k -: 8] : img(seed, k - 4);
      end
      tick(1);
      feed <= 0;
      byte_in <= stream[0];
      byte_last_in <= 1'b0;
      byte_valid_in <= valid;
      sync_seen <= 1'b0;
      start_in <= 1'b1;
      tick(1);
      start_in <= 1'b0;
   endtask
   task automatic wait_end;
      tick(2);
      for (int i = 0; i < 4000 && ok_out !== 1'b1 && error_out !== 1'b1; i++) tick(1);
      tick(6);
      @(negedge clk_in);
   endtask
   task automatic read_byte(input int k, input logic [7:0] exp);
      tick(1);
      cfg_addr_in <= $bits(cfg_addr_in)'(k);
      tick(1);
      @(negedge clk_in);
      check(cfg_data_out === exp, "stored byte");
   endtask
   task automatic pulse_f(input logic sel);
      tick(1);
      link_f.ss_n <= sel;
      link_f.config_reset_n <= 1'b0;
      tick(cfg_load_pkg::RESET_LOW_CYCLES);
      link_f.config_reset_n <= 1'b1;
      tick(WAIT + 10);
      @(negedge clk_in);
   endtask
   task automatic send_f(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         tick(1);
         link_f.sck <= 1'b0;
         link_f.si <= b[i];
         tick(HALF);
         link_f.sck <= 1'b1;
         tick(HALF - 1);
      end
   endtask
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      tick(6);
      rstn_in <= 1'b1;
      load(8'h3C, 1'b1);
      tick(100);
      @(negedge clk_in);
      check(link.load_complete_flag === 1'b0 && master_mode_out === 1'b0, "done early");
      check(link.so_level === 1'b1 && configured_out === 1'b0, "output used in load");
      wait_end();
      check(ok_out === 1'b1 && error_out === 1'b0 && busy_out === 1'b0 && load_error_out === 1'b0, "host status");
      check(link.load_complete_flag === 1'b1, "done not released");
      check(sync_seen === 1'b1, "sync word order on wire");
      check(configured_out === 1'b1 && user_pins_out[2:1] === 2'b11, "pins not handed over");
      for (int k = 0; k < NB; k++) read_byte(k, img(8'h3C, k));
      tick(1);
      user_so_in <= 1'b0;
      tick(4);
      @(negedge clk_in);
      check(link.so_level === 1'b0, "user output not on pin");
      load(8'hC5, 1'b1);
      for (int i = 0; i < 10 && link.config_reset_n !== 1'b0; i++) tick(1);
      for (int i = 0; i < 10 && link.config_reset_n !== 1'b1; i++) tick(1);
      tick(30);
      @(negedge clk_in);
      check(configured_out === 1'b0 && link.load_complete_flag === 1'b0, "no restart");
      read_byte(3, 8'h00);
      wait_end();
      check(ok_out === 1'b1 && link.load_complete_flag === 1'b1, "reload failed");
      for (int k = 0; k < NB; k++) read_byte(k, img(8'hC5, k));
      load(8'h00, 1'b0);
      wait_end();
      check(error_out === 1'b1 && ok_out === 1'b0, "missing byte not refused");
      check(link.load_complete_flag === 1'b0 && configured_out === 1'b0, "done after failure");
      pulse_f(1'b1);
      check(master_b === 1'b1, "select high must pick master mode");
      pulse_f(1'b0);
      check(master_b === 1'b0 && configured_b === 1'b0, "select low must pick peripheral");
      for (int k = 0; k < 9; k++) send_f(stream[k]);
      tick(1);
      link_f.ss_n <= 1'b1;
      for (int k = 9; k < LEN; k++) send_f(stream[k]);
      @(negedge clk_in);
      check(error_b === 1'b1 && link_f.load_complete_flag === 1'b0, "broken load kept done");
      pulse_f(1'b0);
      check(error_b === 1'b0, "reset pulse did not clear failure");
      for (int k = 0; k < LEN; k++) send_f(stream[k]);
      for (int k = 0; k < 7; k++) send_f(8'hFF);
      @(negedge clk_in);
      check(link_f.load_complete_flag === 1'b1 && configured_b === 1'b1, "driver load failed");
      tally_and_finish();
   end
   initial begin
      tick(20000);
      mismatches++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
